// *** design/cssd_top.sv ***
// Clock source selection, write protection, locks and oscillation stop detection.
//
// Added by the designer: strobed register access and the register offsets.
`include "cssd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cssd_top #(
  parameter int STOP_WIN = `CSSD_STOP_WIN_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic main_osc_in_i,
  input wire logic sub_osc_in_i,
  input wire logic onchip_osc_in_i,
  input wire logic wait_i,
  output logic main_osc_out_o,
  output logic main_osc_en_o,
  output logic sub_osc_en_o,
  output logic onchip_osc_en_o,
  output logic pll_enable_o,
  output logic [15:0] pll_ctrl_o,
  output cssd_pkg::cssd_src_t cpu_src_o,
  output cssd_pkg::cssd_src_t periph_src_o,
  output logic [3:0] cpu_div_o,
  output logic cpu_clk_gate_o,
  output logic periph_clk_run_o,
  output logic wdt_src_onchip_o,
  output logic wdt_run_o,
  output logic f2n_src_onchip_o,
  output logic stop_mode_o,
  output logic stop_detect_irq_o
);
  import cssd_pkg::*;

  typedef struct packed {
    logic [7:0] protect;
    logic [7:0] clka;
    logic [7:0] clkb;
    logic [7:0] clkc;
    logic [7:0] pmode;
    logic [15:0] pll;
    logic [15:0] rdata;
    logic stop;
    logic irq;
    cssd_src_t cpu_src;
    cssd_src_t periph_src;
    cssd_src_t want_src;
    cssd_sw_t sw;
    logic [3:0] div;
  } cssd_state_t;
  cssd_state_t s_q, s_d;

  logic main_alive;
  logic main_edge;

  cssd_edge_mon #(
    .WIN(STOP_WIN)
  ) u_main_mon (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .osc_i(main_osc_in_i),
    .edge_o(main_edge),
    .alive_o(main_alive)
  );

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off, input logic w);
    wr_hit = w && (a == off);
  endfunction

  function automatic cssd_src_t pick_src(input logic [7:0] ca, input logic [7:0] cb,
                                         input logic [7:0] cc);
    // Sub select outranks the on-chip select, so a stop detected in low-speed mode
    // moves only the peripheral clock over to the on-chip oscillator.
    if (ca[`CSSD_BIT_SUB_SEL])
    begin
      pick_src = CSSD_SRC_SUB;
    end
    else if (cc[`CSSD_BIT_OCO_SEL])
    begin
      pick_src = CSSD_SRC_OCO;
    end
    else if (cb[`CSSD_BIT_PLL_SEL])
    begin
      pick_src = CSSD_SRC_PLL;
    end
    else
    begin
      pick_src = CSSD_SRC_MAIN;
    end
  endfunction

  logic clk_unlock, mode_unlock, chg_lock, wdt_lock, periph_run, detect;
  logic [7:0] frz_a, frz_b;

  always_comb
  begin
    s_d = s_q;
    clk_unlock = s_q.protect[`CSSD_BIT_CLK_UNLOCK];
    mode_unlock = s_q.protect[`CSSD_BIT_MODE_UNLOCK];
    chg_lock = s_q.pmode[`CSSD_BIT_CHG_LOCK];
    wdt_lock = s_q.pmode[`CSSD_BIT_WDT_LOCK];
    frz_a = 8'h00;
    frz_b = 8'h00;
    // Peripheral clock stops in wait mode only when asked to, or in stop mode.
    periph_run = !s_q.stop && !(wait_i && s_q.clka[`CSSD_BIT_WAIT_PSTOP] && !chg_lock);
    detect = s_q.clkc[`CSSD_BIT_SD_EN] && periph_run && !main_alive && !s_q.stop;
    if (wr_hit(addr_i, `CSSD_ADDR_PROTECT, wr_i))
    begin
      s_d.protect = {6'h00, wdata_i[1:0]};
    end
    if (wr_hit(addr_i, `CSSD_ADDR_CLKA, wr_i) && clk_unlock)
    begin
      frz_a = (8'h01 << `CSSD_BIT_WAIT_PSTOP) | (8'h01 << `CSSD_BIT_MAIN_STOP) |
              (8'h01 << `CSSD_BIT_SUB_SEL);
      if (!chg_lock)
      begin
        frz_a = 8'h00;
      end
      s_d.clka = (wdata_i[7:0] & ~frz_a) | (s_q.clka & frz_a);
    end
    if (wr_hit(addr_i, `CSSD_ADDR_CLKB, wr_i) && clk_unlock)
    begin
      frz_b = 8'h00;
      if (chg_lock)
      begin
        frz_b = (8'h01 << `CSSD_BIT_STOP_REQ) | (8'h01 << `CSSD_BIT_PLL_SEL);
      end
      if (wdt_lock)
      begin
        frz_b = frz_b | (8'h01 << `CSSD_BIT_STOP_REQ);
      end
      s_d.clkb = (wdata_i[7:0] & ~frz_b) | (s_q.clkb & frz_b);
    end
    if (wr_hit(addr_i, `CSSD_ADDR_CLKC, wr_i) && clk_unlock)
    begin
      if (!chg_lock)
      begin
        s_d.clkc[`CSSD_BIT_SD_EN] = wdata_i[`CSSD_BIT_SD_EN];
      end
      s_d.clkc[`CSSD_BIT_OCO_SEL] = wdata_i[`CSSD_BIT_OCO_SEL];
      if (!wdata_i[`CSSD_BIT_SD_FLAG])
      begin
        s_d.clkc[`CSSD_BIT_SD_FLAG] = 1'b0;
      end
    end
    if (wr_hit(addr_i, `CSSD_ADDR_PMODE, wr_i) && mode_unlock)
    begin
      s_d.pmode = wdata_i[7:0];
      s_d.pmode[`CSSD_BIT_CHG_LOCK] = chg_lock | wdata_i[`CSSD_BIT_CHG_LOCK];
      s_d.pmode[`CSSD_BIT_WDT_LOCK] = wdt_lock | wdata_i[`CSSD_BIT_WDT_LOCK];
    end
    if (wr_hit(addr_i, `CSSD_ADDR_PLL, wr_i) && clk_unlock && !chg_lock)
    begin
      s_d.pll = wdata_i;
    end
    // The halted status follows the monitor; only its rising edge counts as a detection.
    s_d.clkc[`CSSD_BIT_MAIN_HALT] = !main_alive;
    // Hardware set wins over a same-cycle software clear.
    if (detect && !s_q.clkc[`CSSD_BIT_MAIN_HALT])
    begin
      s_d.clkc[`CSSD_BIT_OCO_SEL] = 1'b1;
      s_d.clkc[`CSSD_BIT_SD_FLAG] = 1'b1;
    end
    s_d.irq = detect && !s_q.clkc[`CSSD_BIT_MAIN_HALT];
    // Stop mode is left on the first rising main input edge; the request then clears itself.
    if (s_d.clkb[`CSSD_BIT_STOP_REQ] && !s_q.stop)
    begin
      s_d.stop = 1'b1;
      s_d.div = `CSSD_RST_DIV;
    end
    else if (s_q.stop && main_edge)
    begin
      s_d.stop = 1'b0;
      s_d.clkb[`CSSD_BIT_STOP_REQ] = 1'b0;
    end
    // Gate the old source, swap while gated, then release: no runt pulses.
    s_d.want_src = pick_src(s_d.clka, s_d.clkb, s_d.clkc);
    unique case (s_q.sw)
      CSSD_SW_RUN:
      begin
        if (s_q.want_src != s_q.cpu_src)
        begin
          s_d.sw = CSSD_SW_GATE;
        end
      end
      CSSD_SW_GATE:
      begin
        s_d.cpu_src = s_q.want_src;
        s_d.sw = CSSD_SW_SWAP;
      end
      CSSD_SW_SWAP:
      begin
        s_d.sw = CSSD_SW_RUN;
      end
      default:
      begin
        s_d.sw = CSSD_SW_RUN;
      end
    endcase
    if (s_d.clkc[`CSSD_BIT_OCO_SEL])
    begin
      s_d.periph_src = CSSD_SRC_OCO;
    end
    else if (s_d.clkb[`CSSD_BIT_PLL_SEL])
    begin
      s_d.periph_src = CSSD_SRC_PLL;
    end
    else
    begin
      s_d.periph_src = CSSD_SRC_MAIN;
    end
    s_d.rdata = 16'h0000;
    if (rd_i)
    begin
      unique case (addr_i)
        `CSSD_ADDR_PROTECT: s_d.rdata = {8'h00, s_q.protect};
        `CSSD_ADDR_CLKA: s_d.rdata = {8'h00, s_q.clka};
        `CSSD_ADDR_CLKB: s_d.rdata = {8'h00, s_q.clkb};
        `CSSD_ADDR_CLKC: s_d.rdata = {8'h00, s_q.clkc};
        `CSSD_ADDR_PMODE: s_d.rdata = {8'h00, s_q.pmode};
        `CSSD_ADDR_PLL: s_d.rdata = s_q.pll;
        `CSSD_ADDR_STAT: s_d.rdata = {12'h000, s_q.stop, s_q.cpu_src};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q.protect <= 8'h00;
      s_q.clka <= `CSSD_RST_CLKA;
      s_q.clkb <= `CSSD_RST_CLKB;
      s_q.clkc <= 8'h00;
      s_q.pmode <= `CSSD_RST_PMODE;
      s_q.pll <= `CSSD_RST_PLL;
      s_q.rdata <= 16'h0000;
      s_q.stop <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.cpu_src <= CSSD_SRC_MAIN;
      s_q.periph_src <= CSSD_SRC_MAIN;
      s_q.want_src <= CSSD_SRC_MAIN;
      s_q.sw <= CSSD_SW_RUN;
      s_q.div <= `CSSD_RST_DIV;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign main_osc_en_o = !s_q.stop && !s_q.clka[`CSSD_BIT_MAIN_STOP];
  assign main_osc_out_o = !main_osc_en_o;
  assign sub_osc_en_o = !s_q.stop && s_q.clka[`CSSD_BIT_SUB_EN];
  assign wdt_src_onchip_o = s_q.pmode[`CSSD_BIT_WDT_LOCK];
  assign f2n_src_onchip_o = !s_q.pmode[`CSSD_BIT_WDT_LOCK] && !s_q.pmode[`CSSD_BIT_F2N_HI] &&
                            s_q.pmode[`CSSD_BIT_F2N_LO];
  assign onchip_osc_en_o = (!s_q.stop && (s_q.clkc[`CSSD_BIT_OCO_SEL] || f2n_src_onchip_o ||
                            s_q.clkc[`CSSD_BIT_SD_FLAG])) || wdt_src_onchip_o;
  assign pll_enable_o = !s_q.stop && s_q.pll[`CSSD_BIT_PLL_EN];
  assign pll_ctrl_o = s_q.pll;
  assign cpu_src_o = s_q.cpu_src;
  assign periph_src_o = s_q.periph_src;
  assign cpu_div_o = s_q.div;
  // Clock keeps running on wait while the change lock is set.
  assign cpu_clk_gate_o = (s_q.sw == CSSD_SW_RUN) && !s_q.stop &&
                          !(wait_i && !s_q.pmode[`CSSD_BIT_CHG_LOCK]);
  assign periph_clk_run_o = !s_q.stop &&
                            !(wait_i && s_q.clka[`CSSD_BIT_WAIT_PSTOP] &&
                              !s_q.pmode[`CSSD_BIT_CHG_LOCK]);
  assign wdt_run_o = !s_q.stop && (!wait_i || s_q.pmode[`CSSD_BIT_WDT_LOCK]);
  assign stop_mode_o = s_q.stop;
  assign stop_detect_irq_o = s_q.irq;
endmodule
`default_nettype wire

// *** design/cssd_defs.svh ***
// Register offsets, field positions, reset values and timing counts for clock source control.
`ifndef CSSD_DEFS_SVH
`define CSSD_DEFS_SVH
`define CSSD_ADDR_PROTECT 4'h0
`define CSSD_ADDR_CLKA 4'h1
`define CSSD_ADDR_CLKB 4'h2
`define CSSD_ADDR_CLKC 4'h3
`define CSSD_ADDR_PMODE 4'h4
`define CSSD_ADDR_PLL 4'h5
`define CSSD_ADDR_STAT 4'h6
`define CSSD_BIT_CLK_UNLOCK 0
`define CSSD_BIT_MODE_UNLOCK 1
`define CSSD_BIT_WAIT_PSTOP 2
`define CSSD_BIT_SUB_EN 4
`define CSSD_BIT_MAIN_STOP 5
`define CSSD_BIT_SUB_SEL 7
`define CSSD_BIT_STOP_REQ 0
`define CSSD_BIT_PLL_SEL 7
`define CSSD_BIT_SD_EN 0
`define CSSD_BIT_OCO_SEL 1
`define CSSD_BIT_SD_FLAG 2
`define CSSD_BIT_MAIN_HALT 3
`define CSSD_BIT_CHG_LOCK 1
`define CSSD_BIT_WDT_LOCK 2
`define CSSD_BIT_F2N_LO 6
`define CSSD_BIT_F2N_HI 7
`define CSSD_BIT_PLL_EN 7
`define CSSD_RST_CLKA 8'h00
`define CSSD_RST_CLKB 8'h00
`define CSSD_RST_PMODE 8'h00
`define CSSD_RST_PLL 16'h0012
`define CSSD_RST_DIV 4'h8
`define CSSD_CLK_MHZ 50
`define CSSD_MIN_MAIN_MHZ 2
`define CSSD_STOP_WIN_CYC (`CSSD_CLK_MHZ / `CSSD_MIN_MAIN_MHZ)
`endif

// *** design/cssd_pkg.sv ***
// Types shared by the clock source control block.
package cssd_pkg;
  typedef enum logic [2:0] {
    CSSD_SRC_MAIN,
    CSSD_SRC_SUB,
    CSSD_SRC_OCO,
    CSSD_SRC_PLL
  } cssd_src_t;
  typedef enum logic [1:0] {
    CSSD_SW_RUN,
    CSSD_SW_GATE,
    CSSD_SW_SWAP
  } cssd_sw_t;
endpackage

// *** design/cssd_edge_mon.sv ***
// Three-stage sampler and activity watchdog for one oscillator input.
`timescale 1ns/1ps
`default_nettype none
module cssd_edge_mon #(
  parameter int WIN = 25
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic osc_i,
  output logic edge_o,
  output logic alive_o
);
  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [15:0] cnt;
    logic alive;
    logic edge_p;
  } cssd_mon_t;
  cssd_mon_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], osc_i};
    s_d.edge_p = 1'b0;
    // A change counts only once the second and third stages agree on a new level.
    if ((s_q.sync[1] == s_q.sync[2]) && (s_q.sync[2] != s_q.level))
    begin
      s_d.level = s_q.sync[2];
      s_d.edge_p = s_q.sync[2];
      s_d.cnt = 16'h0000;
      s_d.alive = 1'b1;
    end
    else if (s_q.cnt >= 16'(WIN))
    begin
      s_d.alive = 1'b0;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      // Start at the high level of a stopped, pulled-up input so reset makes no false edge.
      s_q <= '{sync: 3'b111, level: 1'b1, cnt: 16'h0000, alive: 1'b0, edge_p: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign edge_o = s_q.edge_p;
  assign alive_o = s_q.alive;
endmodule
`default_nettype wire

// *** dv/cssd_asserts.sv ***
// Port-level checks for the clock source control block.
`timescale 1ns/1ps
`default_nettype none
module cssd_asserts
  import cssd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic wr_i,
  input wire logic main_osc_en_o,
  input wire logic sub_osc_en_o,
  input wire logic onchip_osc_en_o,
  input wire logic pll_enable_o,
  input wire logic [15:0] pll_ctrl_o,
  input wire cssd_pkg::cssd_src_t cpu_src_o,
  input wire cssd_pkg::cssd_src_t periph_src_o,
  input wire logic cpu_clk_gate_o,
  input wire logic periph_clk_run_o,
  input wire logic stop_mode_o,
  input wire logic stop_detect_irq_o
);
  import cssd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_failover;
    stop_detect_irq_o ##[0:3] onchip_osc_en_o;
  endsequence
  a_irq_pulse: assert property (stop_detect_irq_o |=> !stop_detect_irq_o)
    else $error("detect pulse longer than one cycle");
  a_irq_oco: assert property (stop_detect_irq_o |-> s_failover)
    else $error("on-chip oscillator not started on detection");
  a_cpu_oco: assert property (stop_detect_irq_o && cpu_src_o != CSSD_SRC_SUB |->
    ##[0:8] cpu_src_o == CSSD_SRC_OCO)
    else $error("cpu clock not moved to on-chip oscillator");
  a_low_speed: assert property (stop_detect_irq_o && cpu_src_o == CSSD_SRC_SUB |=>
    (cpu_src_o == CSSD_SRC_SUB)[*6] ##0 periph_src_o == CSSD_SRC_OCO)
    else $error("low-speed failover wrong");
  a_stop_halts: assert property (stop_mode_o |->
    !main_osc_en_o && !sub_osc_en_o && !pll_enable_o && !cpu_clk_gate_o)
    else $error("clock still running in stop mode");
  a_pll_write: assert property (!$stable(pll_ctrl_o) |-> $past(wr_i) && $past(addr_i) == 4'h5)
    else $error("pll register changed without a write");
  a_sub_start: assert property ($rose(sub_osc_en_o) |->
    ($past(wr_i) && $past(addr_i) == 4'h1) || $fell(stop_mode_o))
    else $error("sub oscillator started without a write");
  a_swap_gate: assert property ($changed(cpu_src_o) |-> !cpu_clk_gate_o || !$past(cpu_clk_gate_o))
    else $error("cpu source changed with clock ungated");
  a_det_periph: assert property (stop_detect_irq_o |-> $past(periph_clk_run_o))
    else $error("detection while peripheral clock stopped");
endmodule
bind cssd_top cssd_asserts i_asserts (.clk_i, .rstn_i, .addr_i, .wr_i, .main_osc_en_o,
  .sub_osc_en_o, .onchip_osc_en_o, .pll_enable_o, .pll_ctrl_o, .cpu_src_o, .periph_src_o,
  .cpu_clk_gate_o, .periph_clk_run_o, .stop_mode_o, .stop_detect_irq_o);
`default_nettype wire

// *** dv/cssd_osc_model.sv ***
// Main oscillator source feeding the main clock input.
`timescale 1ns/1ps
`default_nettype none
module cssd_osc_model #(
  parameter real HALF_NS = 50.0
) (
  input wire logic en_i,
  input wire logic run_i,
  output logic osc_o
);
  logic ph = 1'b0;
  always #(HALF_NS) ph = !ph;
  // A stopped oscillator leaves the input pulled high through the feedback path.
  assign osc_o = (en_i && run_i) ? ph : 1'b1;
endmodule
`default_nettype wire

// *** dv/cssd_top_tb.sv ***
// Self-checking bench for the clock source control block.
`timescale 1ns/1ps
`default_nettype none
module cssd_top_tb;
  import cssd_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, wait_i = 1'b0, run = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0, rdata_o, pll_ctrl_o, d, p, k, irqs = 16'h0;
  logic main_osc, main_osc_en_o, sub_osc_en_o, onchip_osc_en_o, pll_enable_o, cpu_clk_gate_o;
  logic stop_mode_o, stop_detect_irq_o, wdt_src_onchip_o, f2n_src_onchip_o;
  logic [3:0] cpu_div_o;
  logic main_osc_out_o, periph_clk_run_o, wdt_run_o;
  cssd_src_t cpu_src_o, periph_src_o;
  int failures = 0, n_tests = 0, seed = 46875;
  always #10 clk_i = !clk_i;
  always @(posedge clk_i) if (stop_detect_irq_o === 1'b1) irqs <= irqs + 16'h1;
  cssd_osc_model i_osc (.en_i(main_osc_en_o), .run_i(run), .osc_o(main_osc));
  cssd_top i_dut (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .main_osc_in_i(main_osc), .sub_osc_in_i(1'b0), .onchip_osc_in_i(1'b0), .wait_i,
    .main_osc_out_o, .main_osc_en_o, .sub_osc_en_o, .onchip_osc_en_o, .pll_enable_o,
    .pll_ctrl_o, .cpu_src_o, .periph_src_o, .cpu_div_o, .cpu_clk_gate_o, .periph_clk_run_o,
    .wdt_src_onchip_o, .wdt_run_o, .f2n_src_onchip_o, .stop_mode_o, .stop_detect_irq_o);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    cyc(1);
    chk(cpu_div_o, 16'h8);
    chk(cpu_src_o, CSSD_SRC_MAIN);
    chk({sub_osc_en_o, onchip_osc_en_o}, 16'h0);
    p = 16'h0012;
    for (int i = 0; i < 6; i++)
    begin
      d = 16'($random(seed)) & 16'hff7f;
      wait_i <= 1'($random(seed));
      wr(4'h0, 16'(i % 2));
      wr(4'h5, d);
      if (i % 2)
        p = d;
      chk(pll_ctrl_o, p);
    end
    wr(4'h5, 16'h0092);
    chk(pll_enable_o, 16'h1);
    wait_i <= 1'b1;
    wr(4'h1, 16'h4);
    wr(4'h3, 16'h1);
    chk({periph_clk_run_o, wdt_run_o}, 16'h0);
    k = irqs;
    run <= 1'b0;
    cyc(60);
    chk(irqs, k);
    run <= 1'b1;
    cyc(10);
    wait_i <= 1'b0;
    wr(4'h1, 16'h0);
    for (int m = 0; m < 2; m++)
    begin
      if (m)
      begin
        wr(4'h1, 16'h10);
        chk(sub_osc_en_o, 16'h1);
        wr(4'h1, 16'h90);
        cyc(10);
        chk(cpu_src_o, CSSD_SRC_SUB);
      end
      k = irqs;
      wr(4'h3, 16'h1);
      run <= 1'b0;
      for (int i = 0; i < 100 && irqs == k; i++)
        cyc(1);
      cyc(10);
      chk(irqs, k + 16'h1);
      chk(cpu_src_o, m ? CSSD_SRC_SUB : CSSD_SRC_OCO);
      chk(periph_src_o, CSSD_SRC_OCO);
      rd(4'h3, 16'hf);
      wr(4'h3, 16'h3);
      rd(4'h3, 16'hb);
      run <= 1'b1;
      cyc(20);
      rd(4'h3, 16'h3);
      wr(4'h3, 16'h0);
      wr(4'h1, m ? 16'h10 : 16'h0);
      cyc(10);
      chk(cpu_src_o, CSSD_SRC_MAIN);
    end
    wr(4'h1, 16'h90);
    cyc(5);
    wr(4'h1, 16'hb0);
    chk({main_osc_en_o, main_osc_out_o}, 16'h1);
    wr(4'h1, 16'h90);
    cyc(10);
    wr(4'h1, 16'h10);
    cyc(10);
    run <= 1'b0;
    cyc(3);
    wr(4'h2, 16'h1);
    cyc(3);
    chk({stop_mode_o, main_osc_en_o, main_osc_out_o, sub_osc_en_o, cpu_div_o}, 16'ha8);
    chk(pll_enable_o, 16'h0);
    rstn_i <= 1'b0;
    cyc(2);
    rstn_i <= 1'b1;
    run <= 1'b1;
    cyc(5);
    chk(stop_mode_o, 16'h0);
    wr(4'h0, 16'h1);
    wr(4'h4, 16'h2);
    rd(4'h4, 16'h0);
    wr(4'h0, 16'h3);
    wr(4'h4, 16'h40);
    chk(f2n_src_onchip_o, 16'h1);
    wr(4'h4, 16'h06);
    wr(4'h4, 16'h00);
    rd(4'h4, 16'h06);
    cyc(1);
    chk(rdata_o, 16'h0);
    chk(wdt_src_onchip_o, 16'h1);
    wr(4'h5, 16'h55);
    chk(pll_ctrl_o, 16'h0012);
    wr(4'h2, 16'h1);
    wr(4'h3, 16'h1);
    wr(4'h1, 16'h24);
    wait_i <= 1'b1;
    cyc(3);
    chk({stop_mode_o, cpu_clk_gate_o, wdt_run_o, periph_clk_run_o}, 16'h7);
    rd(4'h3, 16'h0);
    rd(4'h1, 16'h0);
    rd(4'hf, 16'h0);
    summarize();
  end
endmodule
`default_nettype wire
